// ---- hw/ddrimr_core.sv ----
// ddr3 init sequence and mode register decode, as seen from inside the memory
// Function
// RULE_01: eight banks; 8n internal word per access, two beats per clock at pins.
// RULE_02: bursts run eight beats, or four when chopped.
// RULE_03: activate picks bank and row; read/write picks column, A10 AP, A12 BC.
// RULE_04: controller holds reset 200us and drops CKE 10ns before release.
// RULE_05: 500us self initialization after reset release before CKE rises.
// RULE_06: clock stable and NOP/deselect registered before CKE rises.
// RULE_07: CKE stays high until initialization ends.
// RULE_08: termination high impedance under reset and until CKE registered high.
// RULE_09: ODT static from CKE high until initialization completes.
// RULE_10: first MRS waits tXPR after CKE high.
// RULE_11: load MR2, MR3, MR1, MR0 then ZQCL.
// RULE_12: MR1 A0 low enables DLL; MR0 A8 high requests DLL reset.
// RULE_13: controller waits tDLLK and tZQinit after ZQCL.
// RULE_14: warm reset at least 100ns then repeat the init sequence.
// RULE_15: every mode register written fully after reset.
// RULE_16: MRS and DLL reset leave array contents untouched.
// RULE_17: MRS commands spaced by tMRD.
// RULE_18: only NOP/deselect for tMOD after an MRS.
// RULE_19: reprogramming only while idle.
// RULE_20: MRS is CS RAS CAS WE low; BA1:BA0 selects MR0..MR3, BA2 low. BA2 is checked only for MR0; MR1..MR3 load with BA2 high too.
// RULE_21: MR0 A12 chooses slow or fast precharge power-down exit.
// RULE_22: MR0 write recovery codes: reserved,5,6,7,8,10,12,14.
// RULE_23: BA2 and A13..A14 driven zero during MRS.
// RULE_24: write recovery programmed at least ceil(tWR/tCK).
// RULE_25: write recovery code sits on MR0 A11..A9, A11 msb.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
module ddrimr_core #(
	parameter int SELF_INIT_CNT = ddrimr_pkg::SELF_INIT_CYCLES
) (
	// system
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// memory command pins, sampled on the system clock
	input wire logic mem_reset_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic odt_i,
	input wire logic [ddrimr_pkg::BANK_W-1:0] ba_i,
	input wire logic [ddrimr_pkg::ADDR_W-1:0] addr_i,
	// decoded access
	output logic act_o,
	output logic rdwr_o,
	output logic [ddrimr_pkg::BANK_W-1:0] bank_o,
	output logic [ddrimr_pkg::ADDR_W-1:0] row_o,
	output logic [ddrimr_pkg::ADDR_W-1:0] col_o,
	output logic auto_pre_o,
	output logic [3:0] burst_beats_o,
	// init and mode status
	output logic odt_hz_o,
	output logic init_done_o,
	output logic dll_reset_o,
	output logic dll_enable_o,
	output logic fast_pd_exit_o,
	output logic [3:0] wr_cycles_o,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import ddrimr_pkg::*;

	// write recovery decode, 0 marks the reserved code
	function automatic logic [3:0] wr_decode(input logic [2:0] code);
		case (code) // RULE_22
			3'h1: wr_decode = 4'h5;
			3'h2: wr_decode = 4'h6;
			3'h3: wr_decode = 4'h7;
			3'h4: wr_decode = 4'h8;
			3'h5: wr_decode = 4'hA;
			3'h6: wr_decode = 4'hC;
			3'h7: wr_decode = 4'hE;
			default: wr_decode = 4'h0;
		endcase
	endfunction

	// whole state of the block
	typedef struct packed {
		logic [1:0] rstn_sync;
		logic [1:0] cke_sync;
		logic [1:0] cs_sync;
		logic [1:0] ras_sync;
		logic [1:0] cas_sync;
		logic [1:0] we_sync;
		logic [1:0] odt_sync;
		logic [BANK_W-1:0] ba_s1;
		logic [BANK_W-1:0] ba_s2;
		logic [ADDR_W-1:0] addr_s1;
		logic [ADDR_W-1:0] addr_s2;
		ddrimr_state_t st;
		logic [24:0] cnt;
		logic [ADDR_W-1:0] mr0;
		logic [ADDR_W-1:0] mr1;
		logic [ADDR_W-1:0] mr2;
		logic [ADDR_W-1:0] mr3;
		logic [3:0] mr_seen;
		logic act;
		logic rdwr;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic auto_pre;
		logic [3:0] beats;
		logic odt_hz;
		logic dll_rst;
		logic init_done;
		logic dll_en;
		logic [3:0] wr_cyc;
		logic [31:0] wb_dat;
		logic wb_ack;
	} ddrimr_regs_t;

	ddrimr_regs_t s_q, s_d;

	logic rstn_s, cke_s, cs_s, ras_s, cas_s, we_s;
	logic [BANK_W-1:0] ba_s;
	logic [ADDR_W-1:0] addr_s;
	logic cmd_mrs, cmd_act, cmd_rdwr;
	logic [31:0] rd_word;
	logic [ADDR_W-1:0] wr_mr;

	// second flop of each pin synchroniser
	assign rstn_s = s_q.rstn_sync[1];
	assign cke_s = s_q.cke_sync[1];
	assign cs_s = s_q.cs_sync[1];
	assign ras_s = s_q.ras_sync[1];
	assign cas_s = s_q.cas_sync[1];
	assign we_s = s_q.we_sync[1];
	assign ba_s = s_q.ba_s2;
	assign addr_s = s_q.addr_s2;

	// command decode, only while the memory is out of reset with cke high
	// commands seen in the reset state, self init or with cke low are dropped on purpose
	assign cmd_mrs = (s_q.st == DDRIMR_ACTIVE) && cke_s && !cs_s && !ras_s && !cas_s && !we_s;
	assign cmd_act = (s_q.st == DDRIMR_ACTIVE) && cke_s && !cs_s && !ras_s && cas_s && we_s;
	assign cmd_rdwr = (s_q.st == DDRIMR_ACTIVE) && cke_s && !cs_s && ras_s && !cas_s;

	// register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (wb_adr_i)
			REG_MR0: rd_word = {17'h0, s_q.mr0};
			REG_MR1: rd_word = {17'h0, s_q.mr1};
			REG_MR2: rd_word = {17'h0, s_q.mr2};
			REG_MR3: rd_word = {17'h0, s_q.mr3};
			REG_STATUS: begin
				rd_word[ST_RDY_BIT] = (s_q.st == DDRIMR_ACTIVE);
				rd_word[ST_ODTHZ_BIT] = s_q.odt_hz;
				rd_word[ST_DLLRST_BIT] = s_q.dll_rst;
				rd_word[ST_MRSEEN_MSB:ST_MRSEEN_LSB] = s_q.mr_seen;
			end
			REG_WRCYC: rd_word = {28'h0, wr_decode(s_q.mr0[MR0_WR_MSB:MR0_WR_LSB])};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// software write value for a mode register, byte lanes honoured
	always_comb begin
		wr_mr = s_q.mr0;
		case (wb_adr_i)
			REG_MR1: wr_mr = s_q.mr1;
			REG_MR2: wr_mr = s_q.mr2;
			REG_MR3: wr_mr = s_q.mr3;
			default: wr_mr = s_q.mr0;
		endcase
		if (wb_sel_i[0]) begin
			wr_mr[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			wr_mr[14:8] = wb_dat_i[14:8];
		end
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.rstn_sync = {s_q.rstn_sync[0], mem_reset_n_i};
		s_d.cke_sync = {s_q.cke_sync[0], cke_i};
		s_d.cs_sync = {s_q.cs_sync[0], cs_n_i};
		s_d.ras_sync = {s_q.ras_sync[0], ras_n_i};
		s_d.cas_sync = {s_q.cas_sync[0], cas_n_i};
		s_d.we_sync = {s_q.we_sync[0], we_n_i};
		s_d.odt_sync = {s_q.odt_sync[0], odt_i};
		// bank and address take the same two flops so they stay aligned with the command
		s_d.ba_s1 = ba_i;
		s_d.ba_s2 = s_q.ba_s1;
		s_d.addr_s1 = addr_i;
		s_d.addr_s2 = s_q.addr_s1;
		s_d.act = 1'b0;
		s_d.rdwr = 1'b0;
		s_d.dll_rst = 1'b0;

		// init progress; reset pin wins at any point, warm or cold
		case (s_q.st)
			DDRIMR_RESET: begin
				s_d.odt_hz = 1'b1; // RULE_08
				s_d.cnt = 25'h0;
				if (rstn_s) begin
					s_d.st = DDRIMR_SELF_INIT; // RULE_14
				end
			end
			DDRIMR_SELF_INIT: begin
				// internal init runs without the memory clock
				s_d.cnt = s_q.cnt + 25'h1; // RULE_05
				if (s_q.cnt >= 25'(SELF_INIT_CNT - 1)) begin
					s_d.st = DDRIMR_WAIT_CKE;
				end
			end
			DDRIMR_WAIT_CKE: begin
				if (cke_s) begin
					s_d.st = DDRIMR_ACTIVE;
					s_d.odt_hz = 1'b0; // RULE_08
				end
			end
			DDRIMR_ACTIVE: begin
				s_d.odt_hz = 1'b0;
			end
			default: begin
				s_d.st = DDRIMR_RESET;
			end
		endcase
		// a pin mrs in the reset cycle still marks its flag; the state drop keeps done low
		if (!rstn_s) begin
			s_d.st = DDRIMR_RESET;
			s_d.odt_hz = 1'b1; // RULE_08
			s_d.mr_seen = 4'h0; // RULE_15
		end

		// mode register set from the pins; array state is never touched here
		if (cmd_mrs) begin // RULE_20 RULE_16
			case (ba_s[1:0])
				SEL_MR0: begin
					if (!ba_s[2]) begin
						s_d.mr0 = addr_s;
						s_d.mr_seen[0] = 1'b1;
						s_d.dll_rst = addr_s[MR0_DLLRST_BIT]; // RULE_12
					end
				end
				SEL_MR1: begin
					s_d.mr1 = addr_s;
					s_d.mr_seen[1] = 1'b1;
				end
				SEL_MR2: begin
					s_d.mr2 = addr_s;
					s_d.mr_seen[2] = 1'b1;
				end
				default: begin
					s_d.mr3 = addr_s;
					s_d.mr_seen[3] = 1'b1;
				end
			endcase
		end

		// activate latches bank and row, read or write gives column
		if (cmd_act) begin // RULE_03
			s_d.act = 1'b1;
			s_d.bank = ba_s;
			s_d.row = addr_s;
		end
		if (cmd_rdwr) begin // RULE_03
			s_d.rdwr = 1'b1;
			s_d.bank = ba_s;
			s_d.col = addr_s;
			s_d.auto_pre = addr_s[ADDR_AP_BIT];
			// burst length from MR0, chop selectable on the fly by A12
			case (s_q.mr0[MR0_BL_MSB:MR0_BL_LSB]) // RULE_02
				BL_FIX4: s_d.beats = 4'(BURST_CHOP4);
				BL_OTF: s_d.beats = addr_s[ADDR_BC_BIT] ? 4'(BURST_LEN8) : 4'(BURST_CHOP4);
				default: s_d.beats = 4'(BURST_LEN8);
			endcase
		end

		// wishbone classic: one wait state, ack dropped the cycle after
		s_d.wb_ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !s_q.wb_ack) begin
			s_d.wb_ack = 1'b1;
			s_d.wb_dat = rd_word;
			if (wb_we_i) begin
				// software preload; a pin MRS in the same cycle is overridden
				case (wb_adr_i)
					REG_MR0: s_d.mr0 = wr_mr;
					REG_MR1: s_d.mr1 = wr_mr;
					REG_MR2: s_d.mr2 = wr_mr;
					REG_MR3: s_d.mr3 = wr_mr;
					default: s_d.wb_dat = rd_word;
				endcase
			end
		end

		// status outputs registered from the next state, so they line up with the
		// mode registers; a decoder behind the flops could glitch at the pins
		s_d.init_done = (s_d.st == DDRIMR_ACTIVE) && (&s_d.mr_seen); // RULE_15
		s_d.dll_en = !s_d.mr1[MR1_DLLDIS_BIT]; // RULE_12
		s_d.wr_cyc = wr_decode(s_d.mr0[MR0_WR_MSB:MR0_WR_LSB]); // RULE_22
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.st <= DDRIMR_RESET;
			s_q.odt_hz <= 1'b1;
			s_q.beats <= 4'(BURST_LEN8);
			s_q.mr0 <= MR_RESET;
			s_q.mr1 <= MR_RESET;
			s_q.mr2 <= MR_RESET;
			s_q.mr3 <= MR_RESET;
			s_q.dll_en <= !MR_RESET[MR1_DLLDIS_BIT]; // mr1 reset value has the dll on
		end else begin
			s_q <= s_d;
		end
	end

	// outputs, all from flops; BANKS of banks addressed by bank_o
	assign act_o = s_q.act;
	assign rdwr_o = s_q.rdwr;
	assign bank_o = s_q.bank; // RULE_01
	assign row_o = s_q.row;
	assign col_o = s_q.col;
	assign auto_pre_o = s_q.auto_pre;
	assign burst_beats_o = s_q.beats;
	assign odt_hz_o = s_q.odt_hz;
	assign init_done_o = s_q.init_done;
	assign dll_reset_o = s_q.dll_rst;
	assign dll_enable_o = s_q.dll_en; // RULE_12
	assign fast_pd_exit_o = s_q.mr0[MR0_PPD_BIT]; // RULE_21
	// reads 0 for the reserved code, so software can spot an unset field
	assign wr_cycles_o = s_q.wr_cyc; // RULE_25
	assign wb_dat_o = s_q.wb_dat;
	assign wb_ack_o = s_q.wb_ack;

endmodule

// ---- hw/ddrimr_pkg.sv ----
// package: constants, mode register layout and states of the ddr3 init and mode register block
package ddrimr_pkg;

	// clock and timing
	localparam int CLK_MHZ = 50;
	localparam int RESET_SELF_INIT_US = 500;
	localparam int SELF_INIT_CYCLES = RESET_SELF_INIT_US * CLK_MHZ;
	localparam int BANKS = 8;
	localparam int BURST_LEN8 = 8;
	localparam int BURST_CHOP4 = 4;
	localparam int ADDR_W = 15;
	localparam int BANK_W = 3;

	// address bits of read/write commands
	localparam int ADDR_AP_BIT = 10;
	localparam int ADDR_BC_BIT = 12;

	// mode register field positions
	localparam int MR0_PPD_BIT = 12;
	localparam int MR0_WR_MSB = 11;
	localparam int MR0_WR_LSB = 9;
	localparam int MR0_DLLRST_BIT = 8;
	localparam int MR0_TEST_BIT = 7;
	localparam int MR0_BL_MSB = 1;
	localparam int MR0_BL_LSB = 0;
	localparam int MR1_DLLDIS_BIT = 0;

	// mode register select values on ba[1:0]
	localparam logic [1:0] SEL_MR0 = 2'h0;
	localparam logic [1:0] SEL_MR1 = 2'h1;
	localparam logic [1:0] SEL_MR2 = 2'h2;
	localparam logic [1:0] SEL_MR3 = 2'h3;

	// burst length field codes
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;

	// wishbone register byte addresses
	localparam logic [7:0] REG_MR0 = 8'h00;
	localparam logic [7:0] REG_MR1 = 8'h04;
	localparam logic [7:0] REG_MR2 = 8'h08;
	localparam logic [7:0] REG_MR3 = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_WRCYC = 8'h14;

	// status register bits
	localparam int ST_RDY_BIT = 0;
	localparam int ST_ODTHZ_BIT = 1;
	localparam int ST_DLLRST_BIT = 2;
	localparam int ST_MRSEEN_MSB = 6;
	localparam int ST_MRSEEN_LSB = 3;

	// reset values
	localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;

	// init progress states
	typedef enum logic [3:0] {
		DDRIMR_RESET = 4'h1,
		DDRIMR_SELF_INIT = 4'h2,
		DDRIMR_WAIT_CKE = 4'h4,
		DDRIMR_ACTIVE = 4'h8
	} ddrimr_state_t;

endpackage

// ---- bench/ddrimr_ctrl_model.sv ----
// controller-side model driving the memory reset, clock enable and command pins
module ddrimr_ctrl_model #(
	parameter int INIT_WAIT = 30,
	parameter int TMOD = 12
) (
	input wire logic clk_sys_i,
	output logic mem_reset_n_o,
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic odt_o,
	output logic [ddrimr_pkg::BANK_W-1:0] ba_o,
	output logic [ddrimr_pkg::ADDR_W-1:0] addr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import ddrimr_pkg::*;

	// odt stays low and static throughout
	initial begin
		{mem_reset_n_o, cke_o, odt_o} = 3'h0;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = 3'h0;
		addr_o = 15'h0000;
	end

	// reset pulse, then the self init wait with cke still low
	task automatic hold_reset();
		@(posedge clk_sys_i);
		mem_reset_n_o <= 1'b0;
		cke_o <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		mem_reset_n_o <= 1'b1;
		repeat (INIT_WAIT) @(posedge clk_sys_i);
	endtask

	// deselect already registered, so cke may rise and then stays up
	task automatic raise_cke();
		cke_o <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
	endtask

	// one command cycle, then deselect with the bus inverted so no stale value lingers
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		@(posedge clk_sys_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
		ba_o <= b;
		addr_o <= a;
		@(posedge clk_sys_i);
		cs_n_o <= 1'b1;
		ba_o <= ~b;
		addr_o <= ~a;
		repeat (TMOD) @(posedge clk_sys_i);
	endtask
endmodule

// ---- bench/ddrimr_core_sva.sv ----
// concurrent checks on the init and mode register block ports
module ddrimr_core_sva #(
	parameter int SELF_INIT_CNT = 20
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic mem_reset_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [2:0] ba_i,
	input wire logic [14:0] addr_i,
	input wire logic act_o,
	input wire logic rdwr_o,
	input wire logic [14:0] col_o,
	input wire logic [2:0] bank_o,
	input wire logic [14:0] row_o,
	input wire logic odt_hz_o,
	input wire logic init_done_o,
	input wire logic dll_reset_o,
	input wire logic [3:0] wr_cycles_o,
	input wire logic [3:0] burst_beats_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_hz_in_reset: assert property (!mem_reset_n_i |-> ##[1:4] odt_hz_o)
		else $error("termination active under memory reset");
	a_done_no_hz: assert property (init_done_o |-> !odt_hz_o)
		else $error("init done with termination off");
	a_reset_clears: assert property ($fell(mem_reset_n_i) |-> ##[1:4] !init_done_o)
		else $error("init done survives memory reset");
	a_dll_reset: assert property (
		!cs_n_i && !ras_n_i && !cas_n_i && !we_n_i && ba_i == 3'h0
		&& addr_i[8] && cke_i && !odt_hz_o |-> ##3 dll_reset_o)
		else $error("dll reset pulse missing");
	a_act_decode: assert property (
		!cs_n_i && !ras_n_i && cas_n_i && we_n_i && cke_i && !odt_hz_o
		|-> ##3 act_o && bank_o == $past(ba_i, 3) && row_o == $past(addr_i, 3))
		else $error("activate not decoded");
	a_rdwr_decode: assert property (
		!cs_n_i && ras_n_i && !cas_n_i && cke_i && !odt_hz_o
		|-> ##3 rdwr_o && bank_o == $past(ba_i, 3) && col_o == $past(addr_i, 3))
		else $error("read or write not decoded");
	a_wr_legal: assert property (wr_cycles_o inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE})
		else $error("write recovery value illegal");
	a_beats_legal: assert property (burst_beats_o == 4'h8 || burst_beats_o == 4'h4)
		else $error("burst length illegal");
endmodule
bind ddrimr_core ddrimr_core_sva #(.SELF_INIT_CNT(SELF_INIT_CNT)) u_sva (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mem_reset_n_i(mem_reset_n_i), .cke_i(cke_i),
	.cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i),
	.addr_i(addr_i), .act_o(act_o), .bank_o(bank_o), .row_o(row_o), .odt_hz_o(odt_hz_o),
	.rdwr_o(rdwr_o), .col_o(col_o),
	.init_done_o(init_done_o), .dll_reset_o(dll_reset_o), .wr_cycles_o(wr_cycles_o),
	.burst_beats_o(burst_beats_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// ---- bench/ddrimr_core_bench.sv ----
// self-checking bench: pin model plus wishbone register traffic
module ddrimr_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ddrimr_pkg::*;

	logic clk_sys_i, rst_i, mr, cke, cs, ras, cas, we, odt, act, rdwr, ap, hz, done, dllr, dlle, fpd;
	logic [2:0] ba, bank;
	logic [14:0] addr, row, col;
	logic [3:0] beats, wrc, wb_sel_i;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int n_errors, compares;
	logic [3:0] wr_tab [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};
	logic [1:0] mr_order [4] = '{SEL_MR2, SEL_MR3, SEL_MR1, SEL_MR0};

	ddrimr_core #(.SELF_INIT_CNT(20)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.mem_reset_n_i(mr), .cke_i(cke), .cs_n_i(cs), .ras_n_i(ras), .cas_n_i(cas), .we_n_i(we),
		.odt_i(odt), .ba_i(ba), .addr_i(addr), .act_o(act), .rdwr_o(rdwr), .bank_o(bank),
		.row_o(row), .col_o(col), .auto_pre_o(ap), .burst_beats_o(beats), .odt_hz_o(hz),
		.init_done_o(done), .dll_reset_o(dllr), .dll_enable_o(dlle), .fast_pd_exit_o(fpd),
		.wr_cycles_o(wrc), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o));
	ddrimr_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .mem_reset_n_o(mr), .cke_o(cke),
		.cs_n_o(cs), .ras_n_o(ras), .cas_n_o(cas), .we_n_o(we), .odt_o(odt), .ba_o(ba),
		.addr_o(addr));

	// 50 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic cycle; ack and data are read at the edge that samples them
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic summarize();
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// a hang is cut short long after the sequence should end
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		n_errors++;
		summarize();
	end

	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		chk(hz, 1'b1);
		u_ctrl.hold_reset();
		chk(hz, 1'b1);
		u_ctrl.raise_cke();
		chk(hz, 1'b0);
		for (int i = 0; i < 4; i++) begin
			chk(done, 1'b0);
			u_ctrl.cmd(4'h0, {1'b0, mr_order[i]}, (i == 3) ? 15'h1B01 : 15'h0000);
		end
		u_ctrl.cmd(4'h6, 3'h0, 15'h0400);
		chk({done, dlle, fpd, wrc}, {3'h7, 4'hA});
		// status: active, termination on, no dll pulse, all four registers written
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0000_0079);
		wb(1'b0, REG_WRCYC, 32'h0);
		chk(rd, 32'h0000_000A);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, REG_MR0, 32'h1 | (i << 9));
			chk(wrc, wr_tab[i]);
			wb(1'b0, REG_MR0, 32'h0);
			chk(rd, 32'h1 | (i << 9));
		end
		u_ctrl.cmd(4'h3, 3'h5, 15'h1234);
		chk({bank, row}, {3'h5, 15'h1234});
		u_ctrl.cmd(4'h5, 3'h5, 15'h1404);
		chk({col[9:0], ap, beats}, {10'h004, 1'b1, 4'h8});
		u_ctrl.cmd(4'h4, 3'h5, 15'h0003);
		chk({col[9:0], ap, beats}, {10'h003, 1'b0, 4'h4});
		wb(1'b1, 8'h40, 32'hFFFF);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		// reprogram mr0 from the pins once the bursts are over and the memory idles
		u_ctrl.cmd(4'h0, 3'h0, 15'h0A00);
		chk({done, fpd, wrc}, {2'h2, 4'hA});
		u_ctrl.hold_reset();
		chk({done, hz}, 2'h1);
		summarize();
	end
endmodule
